// file: rtl/ais_pkg.sv
package ais_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h09;
  localparam logic [7:0] ADDR_FEATURE_SELECT = 8'h0D;
  localparam logic [7:0] RESET_INTERRUPT_FLAGS = 8'h00;
  localparam logic [7:0] RESET_FEATURE_SELECT = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // Interrupt flag bit positions
  // ---------------------------------------------------------------
  localparam int BIT_WAKE = 2;
  localparam int BIT_ACQ = 3;
  localparam int BIT_EMPTY = 4;
  localparam int BIT_FULL = 5;
  localparam int BIT_LEVEL = 6;
  localparam int BIT_WATCH = 7;
  localparam logic [7:0] FLAG_WRITABLE_MASK = 8'hFC;

  // ---------------------------------------------------------------
  // Feature register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_FREEZE = 3;
  localparam int BIT_REARM = 4;
  localparam int BIT_THREE_WIRE = 5;
  localparam int BIT_TWO_WIRE = 6;
  localparam int BIT_FOUR_WIRE = 7;
  localparam logic [7:0] FEATURE_WRITABLE_MASK = 8'hF8;

  // ---------------------------------------------------------------
  // Operating mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_ACTIVITY_WATCH = 3'h2;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h5;
  localparam logic [2:0] MODE_WATCH_AND_SAMPLE = 3'h6;
  localparam logic [2:0] MODE_TRIGGERED_BURST = 3'h7;

  localparam int FIFO_DEPTH_DEFAULT = 32;
  localparam int THRESH_WIDTH_DEFAULT = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic is_spi;
  } ais_req_s;

endpackage : ais_pkg

// file: rtl/ais_irq_iface.sv
`timescale 1ns/1ns
module ais_irq_iface #(
  parameter int FIFO_DEPTH = ais_pkg::FIFO_DEPTH_DEFAULT,
  parameter int THRESH_WIDTH = ais_pkg::THRESH_WIDTH_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic lclk,
  input wire ais_pkg::ais_req_s lk_req,
  input wire logic lk_req_valid,
  output logic lk_busy_q,
  output logic lk_rsp_valid_q,
  output logic [7:0] lk_rdata_q,
  input wire logic powerup_is_spi,
  input wire logic [2:0] mode,
  input wire logic [7:0] int_enable,
  input wire logic write_to_clear_option,
  input wire logic sniff_to_wake,
  input wire logic sample_acquired,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count,
  input wire logic [THRESH_WIDTH-1:0] fifo_threshold,
  input wire logic detector_fire,
  output logic [7:0] interrupt_flags_q,
  output logic any_flag_pending_q,
  output logic [7:0] feature_select_q,
  output logic spi_enable_q,
  output logic two_wire_enable_q,
  output logic serial_out_pin_bidir_q,
  output logic axis_load_enable_q,
  output logic fifo_capture_enable_q,
  output logic detector_armed_q
);

  localparam int CW = $clog2(FIFO_DEPTH+1);

  generate
    if (FIFO_DEPTH < 2 || THRESH_WIDTH < 1 || THRESH_WIDTH > CW) begin : g_bad
      $error("ais_irq_iface: unsupported FIFO_DEPTH or THRESH_WIDTH");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Link domain: request capture and response
  // ---------------------------------------------------------------
  // The request word is held stable while busy, so the mclk side may read it after the toggle settles.
  logic [1:0] lrst_sync_q;
  ais_pkg::ais_req_s lk_hold_q;
  logic lk_req_tgl_q;
  logic [2:0] lk_ack_sync_q;
  logic ack_tgl_q;
  logic [7:0] rdata_q;
  wire lk_rst_n = lrst_sync_q[1];
  wire lk_take = lk_req_valid && !lk_busy_q;
  wire lk_ack_edge = lk_ack_sync_q[2] ^ lk_ack_sync_q[1];
  wire lk_req_tgl_d = lk_take ? ~lk_req_tgl_q : lk_req_tgl_q;
  wire lk_busy_d = lk_take || (lk_busy_q && !lk_ack_edge);
  wire [2:0] lk_ack_sync_d = {lk_ack_sync_q[1:0], ack_tgl_q};
  wire [7:0] lk_rdata_d = lk_ack_edge ? rdata_q : lk_rdata_q;
  ais_pkg::ais_req_s lk_hold_d;
  assign lk_hold_d = lk_take ? lk_req : lk_hold_q;

  always_ff @(posedge lclk) begin
    lrst_sync_q <= {lrst_sync_q[0], rst_n};
  end

  // ---------------------------------------------------------------
  // Link domain: registers
  // ---------------------------------------------------------------

  always_ff @(posedge lclk) begin
    if (!lk_rst_n) begin
      lk_hold_q <= '0;
    end else begin
      lk_hold_q <= lk_hold_d;
    end
  end

  always_ff @(posedge lclk) begin
    if (!lk_rst_n) begin
      lk_req_tgl_q <= 1'b0;
    end else begin
      lk_req_tgl_q <= lk_req_tgl_d;
    end
  end

  always_ff @(posedge lclk) begin
    if (!lk_rst_n) begin
      lk_busy_q <= 1'b0;
    end else begin
      lk_busy_q <= lk_busy_d;
    end
  end

  always_ff @(posedge lclk) begin
    if (!lk_rst_n) begin
      lk_ack_sync_q <= 3'h0;
    end else begin
      lk_ack_sync_q <= lk_ack_sync_d;
    end
  end

  always_ff @(posedge lclk) begin
    if (!lk_rst_n) begin
      lk_rsp_valid_q <= 1'b0;
    end else begin
      lk_rsp_valid_q <= lk_ack_edge;
    end
  end

  always_ff @(posedge lclk) begin
    if (!lk_rst_n) begin
      lk_rdata_q <= 8'h00;
    end else begin
      lk_rdata_q <= lk_rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: access decode
  // ---------------------------------------------------------------
  logic [2:0] req_sync_q;
  logic [1:0] strap_sync_q;
  logic strap_taken_q;
  logic powerup_spi_q;
  logic empty_prev_q;
  logic full_prev_q;

  wire acc = req_sync_q[2] ^ req_sync_q[1];
  wire acc_wr = acc && lk_hold_q.write;
  wire acc_rd = acc && !lk_hold_q.write;
  wire hit_flags = lk_hold_q.addr == ais_pkg::ADDR_INTERRUPT_FLAGS;
  wire hit_feat = lk_hold_q.addr == ais_pkg::ADDR_FEATURE_SELECT;
  wire two_wire_sel = feature_select_q[ais_pkg::BIT_TWO_WIRE];
  wire wr_clear_mode = write_to_clear_option && two_wire_sel;
  wire clr_by_wr = acc_wr && hit_flags && (lk_hold_q.is_spi || wr_clear_mode);
  wire clr_by_rd = acc_rd && hit_flags && !lk_hold_q.is_spi && !wr_clear_mode;
  wire flags_clear = clr_by_wr || clr_by_rd;
  wire [7:0] rd_mux = hit_flags ? interrupt_flags_q : (hit_feat ? feature_select_q : ais_pkg::READ_UNMAPPED);

  // ---------------------------------------------------------------
  // Core domain: flag sources
  // ---------------------------------------------------------------
  wire in_watch_sample = mode == ais_pkg::MODE_WATCH_AND_SAMPLE;
  wire acq_mode = (mode == ais_pkg::MODE_CONTINUOUS) || (mode == ais_pkg::MODE_TRIGGERED_BURST);
  wire [CW-1:0] thresh_ext = CW'(fifo_threshold);
  logic [7:0] flag_set;
  always_comb begin
    flag_set = 8'h00;
    flag_set[ais_pkg::BIT_WAKE] = sniff_to_wake;
    flag_set[ais_pkg::BIT_ACQ] = sample_acquired && acq_mode;
    flag_set[ais_pkg::BIT_EMPTY] = fifo_empty && !empty_prev_q;
    flag_set[ais_pkg::BIT_FULL] = fifo_full && !full_prev_q;
    flag_set[ais_pkg::BIT_LEVEL] = fifo_count >= thresh_ext;
    flag_set[ais_pkg::BIT_WATCH] = detector_fire && in_watch_sample && detector_armed_q;
  end
  wire [7:0] set_gated = flag_set & int_enable & ais_pkg::FLAG_WRITABLE_MASK;
  // A set arriving with the clear wins, so no event is lost in the clearing cycle.
  wire [7:0] flags_d = ((flags_clear ? 8'h00 : interrupt_flags_q) | set_gated) & ais_pkg::FLAG_WRITABLE_MASK;
  wire watch_cleared = flags_clear && interrupt_flags_q[ais_pkg::BIT_WATCH];
  wire rearm = !in_watch_sample || (watch_cleared && feature_select_q[ais_pkg::BIT_REARM]);
  wire armed_d = set_gated[ais_pkg::BIT_WATCH] ? 1'b0 : (rearm ? 1'b1 : detector_armed_q);
  wire [7:0] feat_d = (acc_wr && hit_feat) ? (lk_hold_q.wdata & ais_pkg::FEATURE_WRITABLE_MASK) : feature_select_q;
  wire four_d = feat_d[ais_pkg::BIT_FOUR_WIRE];
  wire three_d = feat_d[ais_pkg::BIT_THREE_WIRE];
  wire two_d = feat_d[ais_pkg::BIT_TWO_WIRE];
  wire spi_d = two_d ? 1'b0 : ((four_d || three_d) ? 1'b1 : powerup_spi_q);
  wire twi_d = (four_d || three_d) ? 1'b0 : (two_d ? 1'b1 : !powerup_spi_q);

  // ---------------------------------------------------------------
  // Core domain: synchronisers and handshake
  // ---------------------------------------------------------------
  wire ack_tgl_d = acc ? ~ack_tgl_q : ack_tgl_q;
  wire [7:0] rdata_d = acc ? rd_mux : rdata_q;
  wire powerup_spi_d = strap_taken_q ? powerup_spi_q : strap_sync_q[1];
  wire axis_d = four_d || three_d || two_d;
  wire capture_d = !(feat_d[ais_pkg::BIT_FREEZE] && flags_d[ais_pkg::BIT_WATCH]);

  always_ff @(posedge mclk) begin
    strap_sync_q <= {strap_sync_q[0], powerup_is_spi};
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      req_sync_q <= 3'h0;
    end else begin
      req_sync_q <= {req_sync_q[1:0], lk_req_tgl_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_tgl_q <= 1'b0;
    end else begin
      ack_tgl_q <= ack_tgl_d;
    end
  end

  // Read data is loaded on the edge that flips the toggle, so the link side takes a settled word after its synchroniser.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // The strap is caught once after release, two stages behind the pin.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      powerup_spi_q <= 1'b0;
    end else begin
      powerup_spi_q <= powerup_spi_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      empty_prev_q <= 1'b0;
    end else begin
      empty_prev_q <= fifo_empty;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      full_prev_q <= 1'b0;
    end else begin
      full_prev_q <= fifo_full;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: flag registers
  // ---------------------------------------------------------------

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      interrupt_flags_q <= ais_pkg::RESET_INTERRUPT_FLAGS;
    end else begin
      interrupt_flags_q <= flags_d;
    end
  end

  // The summary is built from the next flag value, so it never lags the flags by a cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      any_flag_pending_q <= 1'b0;
    end else begin
      any_flag_pending_q <= |flags_d;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: feature and interface outputs
  // ---------------------------------------------------------------

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      feature_select_q <= ais_pkg::RESET_FEATURE_SELECT;
    end else begin
      feature_select_q <= feat_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      spi_enable_q <= 1'b0;
    end else begin
      spi_enable_q <= spi_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      two_wire_enable_q <= 1'b0;
    end else begin
      two_wire_enable_q <= twi_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serial_out_pin_bidir_q <= 1'b0;
    end else begin
      serial_out_pin_bidir_q <= three_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      axis_load_enable_q <= 1'b0;
    end else begin
      axis_load_enable_q <= axis_d;
    end
  end

  // Capture stops on the edge that sets the watch flag, so no later sample overwrites the event.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_capture_enable_q <= 1'b1;
    end else begin
      fifo_capture_enable_q <= capture_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      detector_armed_q <= 1'b1;
    end else begin
      detector_armed_q <= armed_d;
    end
  end

endmodule : ais_irq_iface

// file: verif/ais_host_model.sv
`timescale 1ns/1ns
module ais_host_model (
  input wire logic lclk,
  input wire logic lk_busy_q,
  input wire logic lk_rsp_valid_q,
  input wire logic [7:0] lk_rdata_q,
  output ais_pkg::ais_req_s lk_req,
  output logic lk_req_valid
);
  int slow = 0;
  initial lk_req = '0;
  initial lk_req_valid = 1'b0;
  // Valid drops after one rising edge, so a later free edge never takes the request twice.
  task automatic access(input ais_pkg::ais_req_s r, output logic [7:0] rd, output bit ok);
    ok = 0;
    repeat (slow + 1) @(negedge lclk);
    lk_req = r;
    lk_req_valid = 1'b1;
    @(negedge lclk) lk_req_valid = 1'b0;
    lk_req = ~r;
    for (int n = 0; n < 12 && !ok; n++) @(negedge lclk) ok = lk_rsp_valid_q;
    rd = lk_rdata_q;
  endtask : access
endmodule : ais_host_model

// file: verif/ais_irq_properties.sv
`timescale 1ns/1ns
module ais_irq_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode,
  input wire logic [7:0] int_enable,
  input wire logic sniff_to_wake,
  input wire logic sample_acquired,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic detector_fire,
  input wire logic [7:0] interrupt_flags_q,
  input wire logic any_flag_pending_q,
  input wire logic [7:0] feature_select_q,
  input wire logic spi_enable_q,
  input wire logic axis_load_enable_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire [7:0] f = interrupt_flags_q;
  gate_on_enable_a: assert property ((f & ~$past(f) & ~$past(int_enable)) == 8'h00) else $error("bad gate");
  pend_or_a: assert property (any_flag_pending_q == |f) else $error("bad pending");
  resv_zero_a: assert property (f[1:0] == 2'h0 && feature_select_q[2:0] == 3'h0) else $error("bad resv");
  wake_set_a: assert property (sniff_to_wake && int_enable[2] |=> f[2]) else $error("bad wake");
  acq_mode_a: assert property ($rose(f[3]) |-> $past(sample_acquired && mode[0] && mode[2])) else $error("bad acq");
  empty_edge_a: assert property ($rose(f[4]) |-> $past(fifo_empty)) else $error("bad empty");
  full_edge_a: assert property ($rose(f[5]) |-> $past(fifo_full)) else $error("bad full");
  watch_mode_a: assert property ($rose(f[7]) |-> $past(detector_fire && mode == 3'h6)) else $error("bad watch");
  spi_off_a: assert property (feature_select_q[6] [*2] |-> !spi_enable_q) else $error("bad spi");
  axis_off_a: assert property ((feature_select_q[7:5] == 3'h0) [*2] |-> !axis_load_enable_q) else $error("bad axis");
  watch_c: cover property (f[7]);
  acq_c: cover property ($rose(f[3]));
  spi_off_c: cover property (feature_select_q[6] && !spi_enable_q);
endmodule : ais_irq_checker
bind ais_irq_iface ais_irq_checker ais_irq_checker_i (.*);

// file: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic mclk = 0, lclk = 0, rst_n = 0, powerup_is_spi = 0, write_to_clear_option = 0;
  logic sniff_to_wake = 0, sample_acquired = 0, fifo_empty = 0, fifo_full = 0, detector_fire = 0;
  logic lk_req_valid, lk_busy_q, lk_rsp_valid_q, any_flag_pending_q, spi_enable_q, two_wire_enable_q;
  logic serial_out_pin_bidir_q, axis_load_enable_q, fifo_capture_enable_q, detector_armed_q;
  logic [7:0] lk_rdata_q, interrupt_flags_q, feature_select_q, rd, int_enable = 8'h00;
  logic [2:0] mode = 3'h5;
  logic [5:0] fifo_count = 6'h00;
  logic [4:0] fifo_threshold = 5'h1F;
  logic [31:0] lfsr = 32'hB6E2;
  logic [2:0] modes [4] = '{3'h2, 3'h5, 3'h6, 3'h7};
  ais_pkg::ais_req_s lk_req;
  int fails = 0, checked = 0, mdl;
  int exp_q[$];
  bit ok;
  wire [7:0] fl = interrupt_flags_q;
  always #50 mclk = ~mclk;
  always #80 lclk = ~lclk;
  ais_irq_iface ais_irq_iface_i (.*);
  ais_host_model ais_host_model_i (.*);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, input logic [7:0] w, input logic wr, input logic spi);
    lfsr = nxt(lfsr);
    ais_host_model_i.access('{a, w, wr, spi}, rd, ok);
    chk(8'(ok), 8'h01);
    repeat (2) @(negedge mclk);
    chk(8'(lk_busy_q), 8'h00);
  endtask : acc
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk) s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : pulse
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge lclk);
    @(negedge mclk);
    acc(8'h09, 8'h00, 0, 0);
    chk(rd, 8'h00);
    acc(8'h0D, 8'h00, 0, 0);
    chk(rd, 8'h00);
    acc(8'h3F, 8'h00, 0, 0);
    chk(rd, 8'h00);
    chk({axis_load_enable_q, spi_enable_q, two_wire_enable_q}, 8'h01);
    pulse(sample_acquired);
    chk(fl, 8'h00);
    int_enable = 8'hFF;
    pulse(sample_acquired);
    chk({any_flag_pending_q, fl[6:0]}, 8'h88);
    acc(8'h09, 8'h00, 0, 0);
    chk(rd, 8'h08);
    chk({any_flag_pending_q, fl[6:0]}, 8'h00);
    $display("test done: reset and gating");
    for (int i = 0; i < 4; i++) begin
      mode = modes[i];
      pulse(sample_acquired);
      pulse(detector_fire);
      mdl = (mode[0] && mode[2]) ? 'h08 : (mode == 3'h6 ? 'h80 : 0);
      chk(fl, 8'(mdl));
      chk(8'(fifo_capture_enable_q), 8'h01);
      acc(8'h09, lfsr[7:0], 1, 1);
      chk(fl, 8'h00);
    end
    pulse(sniff_to_wake);
    acc(8'h09, 8'h00, 0, 1);
    chk(fl, 8'h04);
    acc(8'h09, lfsr[7:0], 1, 1);
    chk(fl, 8'h00);
    $display("test done: modes");
    for (int i = 4; i < 6; i++) begin
      repeat (2) begin
        {fifo_full, fifo_empty} = 2'(i - 3);
        repeat (2) @(negedge mclk);
        chk(fl, 8'h01 << i);
        acc(8'h09, lfsr[7:0], 1, 1);
        chk(fl, 8'h00);
        {fifo_full, fifo_empty} = 2'h0;
        @(negedge mclk);
      end
    end
    repeat (6) begin
      lfsr = nxt(lfsr);
      fifo_threshold = lfsr[4:0];
      fifo_count = 6'(lfsr[12:8] + lfsr[13]);
      repeat (2) @(negedge mclk);
      exp_q.push_back((fifo_count >= fifo_threshold) ? 8'h40 : 8'h00);
      chk(fl, 8'(exp_q.pop_front()));
      fifo_count = 6'h00;
      fifo_threshold = 5'h1F;
      acc(8'h09, lfsr[7:0], 1, 1);
      chk(fl, 8'h00);
    end
    $display("test done: buffer flags");
    ais_host_model_i.slow = 3;
    acc(8'h0D, 8'h20, 1, 1);
    chk({serial_out_pin_bidir_q, axis_load_enable_q}, 8'h03);
    acc(8'h0D, 8'h80, 1, 1);
    chk({serial_out_pin_bidir_q, two_wire_enable_q}, 8'h00);
    acc(8'h0D, 8'h58, 1, 0);
    acc(8'h0D, 8'h00, 0, 0);
    chk(rd, 8'h58);
    chk(feature_select_q, 8'h58);
    chk({spi_enable_q, two_wire_enable_q}, 8'h01);
    mode = 3'h6;
    pulse(detector_fire);
    chk({fifo_capture_enable_q, detector_armed_q}, 8'h00);
    write_to_clear_option = 1'b1;
    acc(8'h09, 8'h00, 0, 0);
    chk(fl, 8'h80);
    acc(8'h09, lfsr[7:0], 1, 0);
    chk(fl, 8'h00);
    chk({fifo_capture_enable_q, detector_armed_q}, 8'h03);
    $display("test done: feature register");
    powerup_is_spi = 1'b1;
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge lclk);
    @(negedge mclk);
    chk({axis_load_enable_q, spi_enable_q, two_wire_enable_q}, 8'h02);
    chk({any_flag_pending_q, fl[6:0]}, 8'h00);
    acc(8'h0D, 8'h00, 0, 1);
    chk(rd, 8'h00);
    $display("test done: second reset");
    end_of_test();
  end
endmodule : testbench
